// File: rtl/psram_fe_defs.svh
// Constants for the pseudo-static memory command front end
`ifndef PSRAM_FE_DEFS_SVH
`define PSRAM_FE_DEFS_SVH
`define OP_SYNC_RD      8'h80
`define OP_SYNC_WR      8'h00
`define OP_LIN_RD       8'ha0
`define OP_LIN_WR       8'h20
`define OP_REG_RD_A     8'hc0
`define OP_REG_RD_B     8'he0
`define OP_REG_WR_A     8'h40
`define OP_REG_WR_B     8'h60
`define OP_MCOL_RD      8'h04
`define OP_MCOL_WR      8'h84
`define OP_MROW_RD      8'h02
`define OP_MROW_WR      8'h82
`define OP_GLOBAL_RST   8'hff
`define SELF_INIT_TIME_US 150
`define CLK_MHZ           250
`define SELF_INIT_CYCLES  (`SELF_INIT_TIME_US * `CLK_MHZ)
`define PAGE_BYTES        1024
`define BL_CODE_16        3'h0
`define BL_CODE_32        3'h1
`define BL_CODE_64        3'h2
`define BL_CODE_128       3'h3
`define BL_CODE_1K        3'h4
`define CA_POS_LO         3
`define RA_HI_POS         2
`endif

// File: rtl/psram_fe_pkg.sv
// Types for the pseudo-static memory command front end
package psram_fe_pkg;
  typedef enum logic [1:0] {
    WRAP_STD,
    WRAP_HYBRID,
    LINEAR
  } burst_kind_t;

  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_SYNC_RD,
    CMD_SYNC_WR,
    CMD_LIN_RD,
    CMD_LIN_WR,
    CMD_REG_RD,
    CMD_REG_WR,
    CMD_MCOL_RD,
    CMD_MCOL_WR,
    CMD_MROW_RD,
    CMD_MROW_WR,
    CMD_GLOBAL_RST
  } cmd_kind_t;

  // One decoded command with its addresses
  typedef struct packed {
    cmd_kind_t   kind;
    logic [12:0] page_addr_bits;
    logic [9:0]  column_addr_bits;
    logic [7:0]  regsel_high;
    logic [7:0]  regsel_low;
    burst_kind_t burst;
    logic [10:0] burst_len;
    logic        cross_page;
    logic [1:0]  extra_idx;
  } cmd_word_t;
endpackage

// File: rtl/psram_cmd_front_end.sv
// Command and address front end of the double-data-rate pseudo-static memory
`timescale 1ns/100ps
`include "psram_fe_defs.svh"

module psram_cmd_front_end #(
  parameter int unsigned SELF_INIT_CYCLES = `SELF_INIT_CYCLES
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_select_n,
  input  wire logic                   i_hw_reset_n,
  input  wire logic                   i_link_rise,
  input  wire logic                   i_link_fall,
  input  wire logic [7:0]             i_dq,
  input  wire logic                   i_strobe_or_mask,
  input  wire logic [2:0]             i_burst_len_code,
  input  wire logic                   i_hybrid_wrap,
  input  wire logic                   i_rd_active,
  input  wire logic                   i_rd_strobe,
  input  wire logic                   i_cmd_ready,
  output logic                        o_ready,
  output logic                        o_cmd_valid,
  output psram_fe_pkg::cmd_word_t     o_cmd,
  output logic                        o_wr_byte_en,
  output logic                        o_regs_clear,
  output logic                        o_strobe_or_mask,
  output logic                        o_strobe_or_mask_oe
);
  import psram_fe_pkg::*;

  typedef enum logic [1:0] {
    INIT_HOLD,
    INIT_WAIT,
    INIT_DONE
  } init_state_t;

  typedef enum logic [2:0] {
    CA_IDLE,
    CA_ADDR,
    CA_EXTRA,
    CA_PUSH,
    CA_SKIP
  } ca_state_t;

  // Reset release through two flip-flops
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Pin synchronisers; first stage is read only by the second
  logic [12:0] pin_s1_q;
  logic [12:0] pin_s2_q;
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Select idles high; reset pin reads low until seen, so init never starts early
      pin_s1_q <= 13'h0001;
      pin_s2_q <= 13'h0001;
    end else begin
      pin_s1_q <= {i_strobe_or_mask, i_link_fall, i_link_rise, i_dq, i_hw_reset_n, i_select_n};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic       sel_n;
  logic       hwrst_n;
  logic [7:0] dq;
  logic       rise;
  logic       fall;
  logic       mask;
  assign sel_n   = pin_s2_q[0];
  assign hwrst_n = pin_s2_q[1];
  assign dq      = pin_s2_q[9:2];
  assign rise    = pin_s2_q[10];
  assign fall    = pin_s2_q[11];
  assign mask    = pin_s2_q[12];

  // Power-up self-initialisation timer
  localparam int unsigned CW = $clog2(SELF_INIT_CYCLES + 1);
  init_state_t     init_q, init_d;
  logic [CW-1:0]   init_cnt_q, init_cnt_d;
  logic            greset;
  always_comb begin
    init_d     = init_q;
    init_cnt_d = init_cnt_q;
    case (init_q)
      INIT_HOLD: begin
        if (hwrst_n) begin
          init_d     = INIT_WAIT;
          init_cnt_d = '0;
        end
      end
      INIT_WAIT: begin
        if (init_cnt_q == CW'(SELF_INIT_CYCLES - 1)) begin
          init_d = INIT_DONE;
        end else begin
          init_cnt_d = init_cnt_q + CW'(1);
        end
      end
      INIT_DONE: begin
        if (!hwrst_n) begin
          init_d = INIT_HOLD;
        end
      end
      default: init_d = INIT_HOLD;
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_q     <= INIT_HOLD;
      init_cnt_q <= '0;
    end else begin
      init_q     <= init_d;
      init_cnt_q <= init_cnt_d;
    end
  end

  // Command and address capture; edge counter steps on each link edge
  ca_state_t   ca_q, ca_d;
  logic [2:0]  edge_q, edge_d;
  logic [1:0]  pair_q, pair_d;
  cmd_word_t   cw_q, cw_d;
  logic        push;
  logic        buf_ready;
  logic        any_edge;
  logic [3:0]  blen_sel;
  assign any_edge = rise | fall;
  assign blen_sel = {1'b0, i_burst_len_code};
  always_comb begin
    ca_d   = ca_q;
    edge_d = edge_q;
    pair_d = pair_q;
    cw_d   = cw_q;
    push   = 1'b0;
    greset = 1'b0;
    case (ca_q)
      CA_IDLE: begin
        if (!sel_n && rise && init_q == INIT_DONE) begin
          cw_d      = '0;
          cw_d.kind = CMD_NONE;
          case (dq)
            `OP_SYNC_RD:                  cw_d.kind = CMD_SYNC_RD;
            `OP_SYNC_WR:                  cw_d.kind = CMD_SYNC_WR;
            `OP_LIN_RD:                   cw_d.kind = CMD_LIN_RD;
            `OP_LIN_WR:                   cw_d.kind = CMD_LIN_WR;
            `OP_REG_RD_A, `OP_REG_RD_B:   cw_d.kind = CMD_REG_RD;
            `OP_REG_WR_A, `OP_REG_WR_B:   cw_d.kind = CMD_REG_WR;
            `OP_MCOL_RD:                  cw_d.kind = CMD_MCOL_RD;
            `OP_MCOL_WR:                  cw_d.kind = CMD_MCOL_WR;
            `OP_MROW_RD:                  cw_d.kind = CMD_MROW_RD;
            `OP_MROW_WR:                  cw_d.kind = CMD_MROW_WR;
            `OP_GLOBAL_RST:               cw_d.kind = CMD_GLOBAL_RST;
            default:                      cw_d.kind = CMD_NONE;
          endcase
          edge_d = 3'h1;
          pair_d = 2'h0;
          ca_d   = CA_ADDR;
        end else if (!sel_n && rise && dq == `OP_GLOBAL_RST) begin
          greset = 1'b1;
          ca_d   = CA_SKIP;
        end
      end
      CA_ADDR: begin
        if (sel_n) begin
          ca_d = CA_IDLE;
        end else if (any_edge) begin
          edge_d = edge_q + 3'h1;
          case (edge_q)
            3'h1: begin
              cw_d.page_addr_bits[12:10] = dq[2:0];
            end
            3'h2: begin
              cw_d.page_addr_bits[9:2] = dq;
              cw_d.regsel_high        = dq;
            end
            3'h3: begin
              cw_d.page_addr_bits[1:0] = dq[7:6];
              cw_d.column_addr_bits[8:3] = dq[5:0];
            end
            3'h4: ; // Fifth edge carries a zero byte
            default: begin
              cw_d.column_addr_bits[2:0] = dq[2:0];
              cw_d.regsel_low            = dq;
              if (cw_q.kind == CMD_SYNC_RD || cw_q.kind == CMD_SYNC_WR || cw_q.kind == CMD_MCOL_RD ||
                  cw_q.kind == CMD_MCOL_WR || cw_q.kind == CMD_MROW_RD || cw_q.kind == CMD_MROW_WR) begin
                cw_d.burst = i_hybrid_wrap ? WRAP_HYBRID : WRAP_STD;
                cw_d.burst_len = (blen_sel == {1'b0, `BL_CODE_1K}) ? 11'(`PAGE_BYTES) :
                                 11'(11'h10 << blen_sel[1:0]);
              end else begin
                cw_d.burst     = LINEAR;
                cw_d.burst_len = 11'(`PAGE_BYTES);
              end
              cw_d.cross_page = (cw_q.kind == CMD_LIN_RD);
              if (cw_q.kind == CMD_GLOBAL_RST) begin
                greset = 1'b1;
                ca_d   = CA_SKIP;
              end else begin
                ca_d = CA_PUSH;
              end
            end
          endcase
        end
      end
      CA_PUSH: begin
        if (buf_ready) begin
          push   = (cw_q.kind != CMD_NONE);
          edge_d = 3'h0;
          // Pair count survives the push, so the last extra address ends the frame
          ca_d   = ((cw_q.kind inside {CMD_MCOL_RD, CMD_MCOL_WR, CMD_MROW_RD, CMD_MROW_WR}) &&
                    pair_q != 2'h3) ? CA_EXTRA : CA_SKIP;
        end
      end
      CA_EXTRA: begin
        if (sel_n) begin
          ca_d = CA_IDLE;
        end else if (any_edge) begin
          edge_d = edge_q + 3'h1;
          if (cw_q.kind == CMD_MCOL_RD || cw_q.kind == CMD_MCOL_WR) begin
            if (!edge_q[0]) begin
              cw_d.column_addr_bits[8:3] = dq[5:0];
            end else begin
              cw_d.column_addr_bits[2:0] = dq[2:0];
              cw_d.extra_idx = pair_q + 2'h1;
              pair_d = pair_q + 2'h1;
              ca_d   = CA_PUSH;
            end
          end else begin
            case (edge_q[1:0])
              2'h0: cw_d.page_addr_bits[12:10] = dq[2:0];
              2'h1: cw_d.page_addr_bits[9:2] = dq;
              2'h2: begin
                cw_d.page_addr_bits[1:0]   = dq[7:6];
                cw_d.column_addr_bits[8:3] = dq[5:0];
              end
              default: begin
                cw_d.column_addr_bits[2:0] = dq[2:0];
                cw_d.extra_idx = 2'h1;
                pair_d = 2'h3;
                ca_d   = CA_PUSH;
              end
            endcase
          end
        end
      end
      CA_SKIP: begin
        if (sel_n) begin
          ca_d = CA_IDLE;
        end
      end
      default: ca_d = CA_IDLE;
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ca_q   <= CA_IDLE;
      edge_q <= 3'h0;
      pair_q <= 2'h0;
      cw_q   <= '0;
    end else begin
      ca_q   <= ca_d;
      edge_q <= edge_d;
      pair_q <= pair_d;
      cw_q   <= cw_d;
    end
  end

  // Two-entry buffer between capture and the array sequencer
  cmd_word_t  buf_mem_q [2];
  cmd_word_t  buf_mem_d [2];
  logic [1:0] cnt_q, cnt_d;
  logic       rd_ptr_q, rd_ptr_d;
  logic       wr_ptr_q, wr_ptr_d;
  logic       pop;
  assign buf_ready = (cnt_q != 2'h2);
  assign pop       = (cnt_q != 2'h0) && i_cmd_ready;
  always_comb begin
    buf_mem_d = buf_mem_q;
    wr_ptr_d  = wr_ptr_q;
    rd_ptr_d  = rd_ptr_q;
    cnt_d     = cnt_q;
    if (push) begin
      buf_mem_d[wr_ptr_q] = cw_q;
      wr_ptr_d = ~wr_ptr_q;
    end
    if (pop) begin
      rd_ptr_d = ~rd_ptr_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_mem_q[0] <= '0;
      buf_mem_q[1] <= '0;
      wr_ptr_q     <= 1'b0;
      rd_ptr_q     <= 1'b0;
      cnt_q        <= 2'h0;
    end else begin
      buf_mem_q <= buf_mem_d;
      wr_ptr_q  <= wr_ptr_d;
      rd_ptr_q  <= rd_ptr_d;
      cnt_q     <= cnt_d;
    end
  end

  // Registered outputs; strobe driven only during reads
  logic       ready_d;
  logic       valid_d;
  cmd_word_t  cmd_d;
  logic       wbe_d;
  logic       clr_d;
  logic       sm_d;
  logic       sm_oe_d;
  always_comb begin
    ready_d = (init_q == INIT_DONE);
    valid_d = (cnt_d != 2'h0);
    cmd_d   = buf_mem_d[rd_ptr_d];
    wbe_d   = !mask;
    clr_d   = greset || (init_q == INIT_DONE && !hwrst_n);
    sm_oe_d = i_rd_active;
    sm_d    = i_rd_active & i_rd_strobe;
  end
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_ready             <= 1'b0;
      o_cmd_valid         <= 1'b0;
      o_cmd               <= '0;
      o_wr_byte_en        <= 1'b0;
      o_regs_clear        <= 1'b0;
      o_strobe_or_mask    <= 1'b0;
      o_strobe_or_mask_oe <= 1'b0;
    end else begin
      o_ready             <= ready_d;
      o_cmd_valid         <= valid_d;
      o_cmd               <= cmd_d;
      o_wr_byte_en        <= wbe_d;
      o_regs_clear        <= clr_d;
      o_strobe_or_mask    <= sm_d;
      o_strobe_or_mask_oe <= sm_oe_d;
    end
  end
endmodule

// File: bench/psram_fe_checker_sva.sv
// Port checker of the command front end
`timescale 1ns/100ps
module psram_fe_checker
  import psram_fe_pkg::*;
#(
  parameter int unsigned SELF_INIT_CYCLES = 10
) (
  input wire logic      i_sys_clk,
  input wire logic      i_reset_n,
  input wire logic      i_hw_reset_n,
  input wire logic      i_strobe_or_mask,
  input wire logic      i_rd_active,
  input wire logic      i_rd_strobe,
  input wire logic      i_cmd_ready,
  input wire logic      o_ready,
  input wire logic      o_cmd_valid,
  input wire cmd_word_t o_cmd,
  input wire logic      o_wr_byte_en,
  input wire logic      o_regs_clear,
  input wire logic      o_strobe_or_mask,
  input wire logic      o_strobe_or_mask_oe
);
  // One clock domain, so one default clock and reset
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  a_head_stands: assert property (o_cmd_valid && !i_cmd_ready |=> o_cmd_valid && $stable(o_cmd))
    else $error("buffer head changed while stalled");
  a_mask_blocks: assert property (i_strobe_or_mask [*8] |-> !o_wr_byte_en)
    else $error("masked byte still enabled");
  a_mask_passes: assert property (!i_strobe_or_mask [*8] |-> o_wr_byte_en)
    else $error("unmasked byte not enabled");
  a_drive_in_read: assert property (i_rd_active [*2] |-> o_strobe_or_mask_oe)
    else $error("strobe not driven in read");
  a_quiet_in_write: assert property (!i_rd_active [*2] |-> !o_strobe_or_mask_oe)
    else $error("strobe driven outside read");
  a_strobe_follows: assert property (i_rd_active [*2] |-> o_strobe_or_mask == $past(i_rd_strobe))
    else $error("strobe level wrong");
  a_init_after_pin: assert property ($rose(o_ready) |-> $past(i_hw_reset_n, 8))
    else $error("ready rose too soon after pin");
  a_ready_in_time: assert property ($rose(i_hw_reset_n) ##1 i_hw_reset_n [*8] ##1 i_hw_reset_n [*8]
                                    |-> ##[0:12] o_ready)
    else $error("ready late after init");
  a_pin_clears: assert property ($fell(i_hw_reset_n) ##1 !i_hw_reset_n [*3] |-> ##[0:6] o_regs_clear)
    else $error("pin reset gave no clear");
  a_valid_after_init: assert property ($rose(o_cmd_valid) |-> o_ready)
    else $error("command taken before init");
endmodule

bind psram_cmd_front_end psram_fe_checker #(.SELF_INIT_CYCLES(SELF_INIT_CYCLES)) u_chk (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_hw_reset_n(i_hw_reset_n),
  .i_strobe_or_mask(i_strobe_or_mask), .i_rd_active(i_rd_active), .i_rd_strobe(i_rd_strobe),
  .i_cmd_ready(i_cmd_ready), .o_ready(o_ready), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd),
  .o_wr_byte_en(o_wr_byte_en), .o_regs_clear(o_regs_clear), .o_strobe_or_mask(o_strobe_or_mask),
  .o_strobe_or_mask_oe(o_strobe_or_mask_oe));

// File: bench/psram_host_model.sv
// Host controller model: select, edge pulses and command bytes
`timescale 1ns/100ps
module psram_host_model (
  input  wire logic       i_sys_clk,
  output logic            o_select_n,
  output logic            o_link_rise,
  output logic            o_link_fall,
  output logic [7:0]      o_dq
);
  // Idle: select high, no edges while power rises
  initial begin
    o_select_n = 1'b1;
    o_link_rise = 1'b0;
    o_link_fall = 1'b0;
    // Only command frames go out: no sleep entry and no write data phase
    o_dq = 8'h00;
  end

  // Bytes go out on alternating rise and fall pulses; gap makes the host slow
  task automatic send(input logic [7:0] b [12], input int n, input int gap);
    repeat (3) @(posedge i_sys_clk);
    o_select_n <= 1'b0;
    for (int k = 0; k < n; k++) begin
      repeat (gap + 1) @(posedge i_sys_clk);
      o_dq <= b[k];
      o_link_rise <= (k % 2) == 0;
      o_link_fall <= (k % 2) == 1;
      @(posedge i_sys_clk);
      o_link_rise <= 1'b0;
      o_link_fall <= 1'b0;
    end
    repeat (2) @(posedge i_sys_clk);
    o_select_n <= 1'b1;
    // Released bus shows no stale byte
    o_dq <= ~o_dq;
  endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench of the command front end
`timescale 1ns/100ps
module testbench;
  import psram_fe_pkg::*;
  localparam int unsigned INIT_CYC = 10;
  logic       clk, rst_n, hw_n, mask, hyb, rd_act, rd_stb, cmd_rdy;
  logic       sel_n, rise, fall, rdy, vld, wr_en, clr, stb, stb_oe;
  logic [2:0] bl;
  logic [7:0] dq;
  logic [7:0] fr [12];
  cmd_word_t  cmd;
  int         n_errors = 0;
  int         checked = 0;
  int         clears = 0;
  int         n;

  psram_host_model host (.i_sys_clk(clk), .o_select_n(sel_n), .o_link_rise(rise),
    .o_link_fall(fall), .o_dq(dq));
  psram_cmd_front_end #(.SELF_INIT_CYCLES(INIT_CYC)) dut (.i_sys_clk(clk), .i_reset_n(rst_n),
    .i_select_n(sel_n), .i_hw_reset_n(hw_n), .i_link_rise(rise), .i_link_fall(fall), .i_dq(dq),
    .i_strobe_or_mask(mask), .i_burst_len_code(bl), .i_hybrid_wrap(hyb), .i_rd_active(rd_act),
    .i_rd_strobe(rd_stb), .i_cmd_ready(cmd_rdy), .o_ready(rdy), .o_cmd_valid(vld), .o_cmd(cmd),
    .o_wr_byte_en(wr_en), .o_regs_clear(clr), .o_strobe_or_mask(stb), .o_strobe_or_mask_oe(stb_oe));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Count cycles with the clear request high
  always @(posedge clk) begin
    if (clr === 1'b1) begin
      clears <= clears + 1;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Bounded waits; running out ends the run
  task automatic wait_vld();
    for (int k = 0; k < 40 && vld !== 1'b1; k++) @(negedge clk);
    if (vld !== 1'b1) begin
      chk("cmd_valid wait", 16'h1, 16'(vld));
      wrap_up();
    end
  endtask

  task automatic wait_rdy(output int cnt);
    for (cnt = 0; cnt < 200 && rdy !== 1'b1; cnt++) @(negedge clk);
    if (rdy !== 1'b1) begin
      chk("ready wait", 16'h1, 16'(rdy));
      wrap_up();
    end
  endtask

  task automatic pop();
    @(posedge clk);
    cmd_rdy <= 1'b1;
    @(posedge clk);
    cmd_rdy <= 1'b0;
    @(negedge clk);
  endtask

  task automatic set_frame(input logic [7:0] op, a3, a2, a1, a0);
    fr = '{op, a3, a2, a1, 8'h00, a0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  endtask

  // Every sync, linear and register opcode, prompt and slow host
  task automatic t_decode();
    logic [7:0] ops [8] = '{8'h80, 8'h00, 8'ha0, 8'h20, 8'hc0, 8'he0, 8'h40, 8'h60};
    cmd_kind_t  kinds [8] = '{CMD_SYNC_RD, CMD_SYNC_WR, CMD_LIN_RD, CMD_LIN_WR,
                              CMD_REG_RD, CMD_REG_RD, CMD_REG_WR, CMD_REG_WR};
    logic [7:0] a2;
    for (int i = 0; i < 8; i++) begin
      a2 = 8'h96 + 8'(i);
      @(posedge clk);
      hyb <= i[0];
      set_frame(ops[i], i > 3 ? 8'h00 : 8'h05, a2, i > 3 ? 8'h00 : 8'h9a, 8'h05);
      host.send(fr, 6, i % 3);
      wait_vld();
      chk("kind", 16'(kinds[i]), 16'(cmd.kind));
      if (i > 3) begin
        chk("regsel_high", 16'(a2), 16'(cmd.regsel_high));
        chk("regsel_low", 16'h05, 16'(cmd.regsel_low));
      end else begin
        chk("page", 16'({3'h5, a2, 2'h2}), 16'(cmd.page_addr_bits));
        chk("column", 16'h0d5, 16'(cmd.column_addr_bits));
        chk("cross_page", 16'(ops[i] == 8'ha0), 16'(cmd.cross_page));
        chk("burst", 16'(i > 1 ? LINEAR : (i[0] ? WRAP_HYBRID : WRAP_STD)), 16'(cmd.burst));
      end
      pop();
    end
  endtask

  // All five wrap lengths
  task automatic t_lengths();
    for (int c = 0; c < 5; c++) begin
      @(posedge clk);
      bl <= 3'(c);
      hyb <= 1'b0;
      set_frame(8'h80, 8'h05, 8'h11, 8'h9a, 8'h05);
      host.send(fr, 6, 1);
      wait_vld();
      chk("burst_len", c == 4 ? 16'd1024 : 16'd16 << c, 16'(cmd.burst_len));
      pop();
    end
  endtask

  // Two entries fill the buffer while the sequencer stalls
  task automatic t_multi_row();
    set_frame(8'h02, 8'h05, 8'h33, 8'h9a, 8'h05);
    fr[6] = 8'h02;
    fr[7] = 8'h44;
    fr[8] = 8'h40;
    fr[9] = 8'h01;
    host.send(fr, 10, 2);
    wait_vld();
    repeat (6) @(negedge clk);
    chk("kind", 16'(CMD_MROW_RD), 16'(cmd.kind));
    chk("page", 16'({3'h5, 8'h33, 2'h2}), 16'(cmd.page_addr_bits));
    pop();
    chk("second valid", 16'h1, 16'(vld));
    chk("page", 16'({3'h2, 8'h44, 2'h1}), 16'(cmd.page_addr_bits));
    chk("column", 16'h001, 16'(cmd.column_addr_bits));
    pop();
    chk("empty", 16'h0, 16'(vld));
  endtask

  // Multi-column write and read: first address then three column pairs, popped as they come
  task automatic t_multi_col();
    logic [7:0] ops [2] = '{8'h84, 8'h04};
    cmd_kind_t  kinds [2] = '{CMD_MCOL_WR, CMD_MCOL_RD};
    logic [9:0] cols [4] = '{10'h0d5, 10'h008, 10'h010, 10'h1fc};
    int         got;
    for (int j = 0; j < 2; j++) begin
      got = 0;
      @(posedge clk);
      cmd_rdy <= 1'b1;
      bl <= 3'h0;
      set_frame(ops[j], 8'h05, 8'h11, 8'h9a, 8'h05);
      fr[6] = 8'h01;
      fr[7] = 8'h00;
      fr[8] = 8'h02;
      fr[9] = 8'h00;
      fr[10] = 8'h3f;
      fr[11] = 8'h04;
      fork
        host.send(fr, 12, 3);
        for (int k = 0; k < 300 && got < 4; k++) begin
          @(negedge clk);
          if (vld === 1'b1) begin
            chk("mcol kind", 16'(kinds[j]), 16'(cmd.kind));
            chk("mcol column", 16'(cols[got]), 16'(cmd.column_addr_bits));
            chk("mcol index", 16'(got), 16'(cmd.extra_idx));
            got++;
          end
        end
      join
      @(posedge clk);
      cmd_rdy <= 1'b0;
      chk("mcol entries", 16'h4, 16'(got));
      if (got != 4) begin
        wrap_up();
      end
    end
  endtask

  // Mask during writes, strobe during reads
  task automatic t_pin_roles();
    @(posedge clk);
    mask <= 1'b1;
    repeat (6) @(negedge clk);
    chk("byte enable", 16'h0, 16'(wr_en));
    @(posedge clk);
    mask <= 1'b0;
    rd_act <= 1'b1;
    rd_stb <= 1'b1;
    repeat (6) @(negedge clk);
    chk("byte enable", 16'h1, 16'(wr_en));
    chk("strobe", 16'h1, 16'({stb_oe, stb} == 2'b11));
    @(posedge clk);
    rd_stb <= 1'b0;
    repeat (2) @(negedge clk);
    chk("strobe low", 16'h0, 16'(stb));
    @(posedge clk);
    rd_act <= 1'b0;
    repeat (3) @(negedge clk);
    chk("strobe enable", 16'h0, 16'(stb_oe));
  endtask

  // Unknown opcode refused, then a global reset
  task automatic t_refuse_and_clear();
    int c0;
    set_frame(8'h11, 8'h05, 8'h11, 8'h9a, 8'h05);
    host.send(fr, 6, 1);
    repeat (20) @(negedge clk);
    chk("unknown opcode", 16'h0, 16'(vld));
    c0 = clears;
    set_frame(8'hff, 8'h00, 8'h00, 8'h00, 8'h00);
    host.send(fr, 6, 0);
    repeat (10) @(negedge clk);
    chk("clear cycles", 16'h1, 16'(clears - c0));
    if (vld === 1'b1) begin
      pop();
    end
  endtask

  initial begin
    rst_n = 1'b0;
    hw_n = 1'b0;
    mask = 1'b0;
    hyb = 1'b0;
    rd_act = 1'b0;
    rd_stb = 1'b0;
    cmd_rdy = 1'b0;
    bl = 3'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (30) @(negedge clk);
    chk("ready with pin low", 16'h0, 16'(rdy));
    @(posedge clk);
    hw_n <= 1'b1;
    wait_rdy(n);
    chk("init length", 16'h1, 16'(n >= INIT_CYC && n <= INIT_CYC + 8));
    t_decode();
    t_lengths();
    t_multi_row();
    t_multi_col();
    t_pin_roles();
    t_refuse_and_clear();
    n = clears;
    @(posedge clk);
    hw_n <= 1'b0;
    repeat (8) @(posedge clk);
    hw_n <= 1'b1;
    chk("pin reset clear", 16'h1, 16'(clears > n));
    wait_rdy(n);
    wrap_up();
  end
endmodule
